// File: src/pbsp_pkg.sv
// constants for the pipelined burst sram port
// assumes one 200 MHz clock and a synchronous active-high reset
package pbsp_pkg;
  localparam int ADDR_W = 17;
  localparam int LANES  = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int DEPTH  = 131072;
  localparam int BEAT_W = 2;
  localparam int CLK_PERIOD_NS = 5;
  localparam int PIPE_DEPTH    = 2;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTLV  = 1'b1;
  typedef enum logic {PBSP_IDLE, PBSP_BURST} pbsp_state_t;
endpackage : pbsp_pkg

// File: src/pbsp_beat_if.sv
// carrier between the port and its burst address generator
// assumes both ends share core_clk_i
`timescale 1ns/1ps
interface pbsp_beat_if;
  logic [pbsp_pkg::ADDR_W-1:0] base_addr;
  logic [pbsp_pkg::BEAT_W-1:0] beat_cnt;
  logic                        order_sel;
  logic [pbsp_pkg::ADDR_W-1:0] beat_addr;
  modport port (output base_addr, output beat_cnt, output order_sel, input beat_addr);
  modport gen  (input base_addr, input beat_cnt, input order_sel, output beat_addr);
endinterface : pbsp_beat_if

// File: src/pbsp_beat_gen.sv
// burst address generator: low two bits step linear or interleaved
// assumes base and order come from registers of the port, count from cnt_ff plus one
`timescale 1ns/1ps
module pbsp_beat_gen (
  pbsp_beat_if.gen bi
);
  wire [pbsp_pkg::BEAT_W-1:0] low_lin = bi.base_addr[pbsp_pkg::BEAT_W-1:0] + bi.beat_cnt; // R04
  wire [pbsp_pkg::BEAT_W-1:0] low_int = bi.base_addr[pbsp_pkg::BEAT_W-1:0] ^ bi.beat_cnt; // R04
  wire [pbsp_pkg::BEAT_W-1:0] low_sel = (bi.order_sel == pbsp_pkg::ORDER_INTLV) ? low_int : low_lin;
  assign bi.beat_addr = {bi.base_addr[pbsp_pkg::ADDR_W-1:pbsp_pkg::BEAT_W], low_sel}; // R04
endmodule : pbsp_beat_gen

// File: src/pbsp_port.sv
// pipelined burst sram port: storage array, burst control, two-stage data pipeline
// assumes all inputs synchronous to core_clk_i; data pins split into in, out and enable
//
// Overview of operation
// [R01] load input low on an enabled edge ends burst, captures address and control
// [R02] read/write input ignored while advancing a burst
// [R03] read/write level at load fixes every beat of the burst
// [R04] only two low address bits advance, linear or interleaved by order select
// [R05] write starts when read/write is low on a load edge
// [R06] controller drives valid byte selects on every write beat
// [R07] byte selects taken two cycles before their write data
// [R08] clock gate high: edge ignored, every register holds
// [R09] selected only when both low selects low and high select high
// [R10] data bus released from reset until a read drives it
// [R11] data moves two enabled cycles after its address cycle, no gaps
// [R12] deselected load starts nothing; pending transfers finish, then bus released
`timescale 1ns/1ps
module pbsp_port (
  // clock and reset
  input  wire logic                          core_clk_i,
  input  wire logic                          srst_i,
  // address and control
  input  wire logic [pbsp_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic                          rd_wr_i,
  input  wire logic                          advance_or_load_i,
  input  wire logic                          burst_order_select_i,
  input  wire logic                          clock_gate_input_i,
  input  wire logic [pbsp_pkg::LANES-1:0]    byte_lane_write_selects_n_i,
  // chip selects
  input  wire logic                          chip_select_low_a_n_i,
  input  wire logic                          chip_select_low_b_n_i,
  input  wire logic                          chip_select_high_i,
  // data bus
  input  wire logic [pbsp_pkg::DATA_W-1:0]   dq_i,
  output logic      [pbsp_pkg::DATA_W-1:0]   dq_o,
  output logic                               dq_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire edge_en  = ~clock_gate_input_i; // R08
  wire selected = ~chip_select_low_a_n_i & ~chip_select_low_b_n_i & chip_select_high_i; // R09
  wire load     = edge_en & ~advance_or_load_i; // R01
  wire new_op   = load & selected; // R12
  wire advance  = edge_en & advance_or_load_i;

  ////////////////////////////////////////////////////////////////////////////
  // burst state
  pbsp_pkg::pbsp_state_t         state_ff;
  logic [pbsp_pkg::ADDR_W-1:0]   base_ff;
  logic [pbsp_pkg::BEAT_W-1:0]   cnt_ff;
  logic                          order_ff;
  logic                          bwr_ff;
  wire                           bursting = (state_ff == pbsp_pkg::PBSP_BURST);
  wire                           beat_adv = advance & bursting;
  // load already issued beat 0, so an advance fetches the following beat
  wire [pbsp_pkg::BEAT_W-1:0]    cnt_inc  = cnt_ff + pbsp_pkg::BEAT_STEP; // R04

  pbsp_beat_if bi ();
  assign bi.base_addr = base_ff;
  assign bi.beat_cnt  = cnt_inc; // R04
  assign bi.order_sel = order_ff;

  pbsp_beat_gen u_gen (
    .bi (bi.gen)
  );

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= pbsp_pkg::PBSP_IDLE;
      cnt_ff   <= pbsp_pkg::BEAT_FIRST;
      base_ff  <= '0;
      order_ff <= pbsp_pkg::ORDER_LINEAR;
      bwr_ff   <= 1'b0;
    end else if (load) begin // R01
      state_ff <= selected ? pbsp_pkg::PBSP_BURST : pbsp_pkg::PBSP_IDLE; // R12
      cnt_ff   <= pbsp_pkg::BEAT_FIRST;
      base_ff  <= addr_i;
      order_ff <= burst_order_select_i;
      bwr_ff   <= ~rd_wr_i; // R03
    end else if (beat_adv) begin
      cnt_ff <= cnt_inc; // R04
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address stage
  logic                          s1_vld_ff;
  logic                          s1_wr_ff;
  logic [pbsp_pkg::ADDR_W-1:0]   s1_addr_ff;
  logic [pbsp_pkg::LANES-1:0]    s1_bw_ff;
  wire                           nxt_s1_vld  = new_op | beat_adv;
  wire                           nxt_s1_wr   = new_op ? ~rd_wr_i : bwr_ff; // R02 R05
  wire [pbsp_pkg::ADDR_W-1:0]    nxt_s1_addr = new_op ? addr_i : bi.beat_addr;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s1_vld_ff  <= 1'b0;
      s1_wr_ff   <= 1'b0;
      s1_addr_ff <= '0;
      s1_bw_ff   <= '0;
    end else if (edge_en) begin // R08
      s1_vld_ff  <= nxt_s1_vld;
      s1_wr_ff   <= nxt_s1_wr;
      s1_addr_ff <= nxt_s1_addr;
      s1_bw_ff   <= ~byte_lane_write_selects_n_i; // R06 R07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data stage
  logic                          s2_wr_ff;
  logic [pbsp_pkg::ADDR_W-1:0]   s2_addr_ff;
  logic [pbsp_pkg::LANES-1:0]    s2_bw_ff;
  logic [pbsp_pkg::DATA_W-1:0]   mem [pbsp_pkg::DEPTH];
  // write landing on this edge is forwarded to a same-address read
  wire [pbsp_pkg::DATA_W-1:0]    rd_word = mem[s1_addr_ff];
  wire                           fwd_hit = s2_wr_ff & (s2_addr_ff == s1_addr_ff); // R11
  wire [pbsp_pkg::DATA_W-1:0]    rd_merged;

  for (genvar ln = 0; ln < pbsp_pkg::LANES; ln++) begin : g_fwd
    assign rd_merged[ln*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] =
      (fwd_hit & s2_bw_ff[ln]) ? dq_i[ln*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W]
                               : rd_word[ln*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W]; // R11
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s2_wr_ff   <= 1'b0;
      s2_addr_ff <= '0;
      s2_bw_ff   <= '0;
      dq_oe_o    <= 1'b0; // R10
      dq_o       <= '0;
    end else if (edge_en) begin // R08
      s2_wr_ff   <= s1_vld_ff & s1_wr_ff;
      s2_addr_ff <= s1_addr_ff;
      s2_bw_ff   <= s1_bw_ff; // R07
      dq_oe_o    <= s1_vld_ff & ~s1_wr_ff; // R11 R12
      dq_o       <= rd_merged; // R11
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!srst_i && edge_en && s2_wr_ff) begin // R11
      for (int b = 0; b < pbsp_pkg::LANES; b++) begin
        if (s2_bw_ff[b]) begin // R07
          mem[s2_addr_ff][b*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W] <= dq_i[b*pbsp_pkg::LANE_W +: pbsp_pkg::LANE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_load_capture;
    @(posedge core_clk_i) disable iff (srst_i)
    new_op |=> s1_vld_ff && s1_addr_ff == $past(addr_i) && cnt_ff == pbsp_pkg::BEAT_FIRST;
  endproperty
  a_load_capture: assert property (p_load_capture) else $error("load not captured"); // R01

  property p_rw_ignored;
    @(posedge core_clk_i) disable iff (srst_i)
    beat_adv |=> s1_wr_ff == $past(bwr_ff);
  endproperty
  a_rw_ignored: assert property (p_rw_ignored) else $error("read/write sampled mid burst"); // R02

  property p_type_fixed;
    @(posedge core_clk_i) disable iff (srst_i)
    new_op ##1 beat_adv |=> s1_wr_ff == ~$past(rd_wr_i, 2);
  endproperty
  a_type_fixed: assert property (p_type_fixed) else $error("burst type changed"); // R03

  property p_upper_fixed;
    @(posedge core_clk_i) disable iff (srst_i)
    beat_adv |=> s1_addr_ff[pbsp_pkg::ADDR_W-1:pbsp_pkg::BEAT_W] == $past(base_ff[pbsp_pkg::ADDR_W-1:pbsp_pkg::BEAT_W])
      && s1_addr_ff[pbsp_pkg::BEAT_W-1:0] == ($past(order_ff) == pbsp_pkg::ORDER_INTLV
        ? $past(base_ff[pbsp_pkg::BEAT_W-1:0]) ^ ($past(cnt_ff) + pbsp_pkg::BEAT_STEP)
        : $past(base_ff[pbsp_pkg::BEAT_W-1:0]) + $past(cnt_ff) + pbsp_pkg::BEAT_STEP);
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) else $error("burst address out of sequence"); // R04

  property p_beat_step;
    @(posedge core_clk_i) disable iff (srst_i)
    beat_adv |=> cnt_ff == $past(cnt_ff) + pbsp_pkg::BEAT_STEP;
  endproperty
  a_beat_step: assert property (p_beat_step) else $error("burst counter did not step"); // R04

  property p_write_start;
    @(posedge core_clk_i) disable iff (srst_i)
    new_op && !rd_wr_i |=> s1_vld_ff && s1_wr_ff ##1 (!$past(edge_en) || !dq_oe_o);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write not started"); // R05

  property p_gate_hold;
    @(posedge core_clk_i) disable iff (srst_i)
    !edge_en |=> $stable(s1_vld_ff) && $stable(cnt_ff) && $stable(dq_oe_o) && $stable(s2_wr_ff);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("state moved on gated edge"); // R08

  property p_deselect;
    @(posedge core_clk_i) disable iff (srst_i)
    load && !selected |=> !s1_vld_ff && !bursting;
  endproperty
  a_deselect: assert property (p_deselect) else $error("operation started while deselected"); // R09

  property p_reset_release;
    @(posedge core_clk_i)
    srst_i |=> !dq_oe_o;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("bus driven after reset"); // R10

  property p_read_latency;
    @(posedge core_clk_i) disable iff (srst_i)
    new_op && rd_wr_i ##1 edge_en |=> dq_oe_o;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read data not driven on time"); // R11

  property p_bus_release;
    @(posedge core_clk_i) disable iff (srst_i)
    load && !selected ##1 (edge_en && !s1_vld_ff) |=> !dq_oe_o;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus not released after deselect"); // R12

  property p_write_quiet;
    @(posedge core_clk_i) disable iff (srst_i)
    edge_en && s1_vld_ff && s1_wr_ff |=> !dq_oe_o;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven for a write beat"); // R12

  property p_forward;
    @(posedge core_clk_i) disable iff (srst_i)
    edge_en && fwd_hit && s2_bw_ff[0] |=> dq_o[pbsp_pkg::LANE_W-1:0] == $past(dq_i[pbsp_pkg::LANE_W-1:0]);
  endproperty
  a_forward: assert property (p_forward) else $error("read missed write on same edge"); // R11

endmodule : pbsp_port

// File: testbench/pbsp_ctrl_model.sv
// controller model: drives write data two enabled edges after its beat
// assumes the bench flags each write beat in its address cycle
`timescale 1ns/1ps
module pbsp_ctrl_model (
  // clock and gate
  input  wire logic                        core_clk_i,
  input  wire logic                        gate_i,
  // write beat from bench
  input  wire logic                        wv_i,
  input  wire logic [pbsp_pkg::DATA_W-1:0] wd_i,
  // data toward the port
  output logic      [pbsp_pkg::DATA_W-1:0] data_o
);
  logic [1:0]                  v_ff = 2'h0;
  logic [pbsp_pkg::DATA_W-1:0] d1_ff, d2_ff, last_ff = '0;
  always @(posedge core_clk_i) if (!gate_i) begin
    v_ff    <= {v_ff[0], wv_i};
    d1_ff   <= wd_i;
    d2_ff   <= d1_ff;
    last_ff <= data_o;
  end
  // released bus toggles each enabled cycle
  assign data_o = v_ff[1] ? d2_ff : ~last_ff;
endmodule : pbsp_ctrl_model

// File: testbench/tb.sv
// bench for the sram port: bursts, byte lanes, clock gate, selects
// assumes the controller model supplies write data
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, srst = 1'b1, adv = 1'b0, rw = 1'b1, ord = 1'b0, g = 1'b0, wv = 1'b0;
  logic        ord_nx = 1'b0, flip = 1'b0, oe;
  logic [16:0] a = '0;
  logic [3:0]  bw = 4'hf;
  logic [2:0]  cs = 3'b101;
  logic [35:0] wd = '0, dqi, dqo;
  int          n_errors = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  pbsp_port dut (.core_clk_i(clk), .srst_i(srst), .addr_i(a), .rd_wr_i(rw), .advance_or_load_i(adv),
    .burst_order_select_i(ord), .clock_gate_input_i(g), .byte_lane_write_selects_n_i(bw),
    .chip_select_low_a_n_i(cs[2]), .chip_select_low_b_n_i(cs[1]), .chip_select_high_i(cs[0]),
    .dq_i(dqi), .dq_o(dqo), .dq_oe_o(oe));
  pbsp_ctrl_model ctl (.core_clk_i(clk), .gate_i(g), .wv_i(wv), .wd_i(wd), .data_o(dqi));
  ////////////////////////////////////////////////////////////////
  function automatic logic [35:0] pat(input logic [16:0] x);
    return {x[7:0], 11'h5a3, x} ^ 36'h9_c3c3_0f0f;
  endfunction : pat
  task automatic chk(input logic [36:0] e, input logic [36:0] got);
    comparisons++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask : chk
  // one cycle of pins, outputs looked at 1 ns after the edge
  task automatic step(input logic ad, r, w, logic [16:0] x, logic [3:0] b, logic [2:0] c, logic gt);
    @(posedge clk);
    adv <= ad;
    rw  <= r;
    wv  <= w;
    a   <= x;
    bw  <= b;
    cs  <= c;
    g   <= gt;
    ord <= ord_nx;
    wd  <= pat(x) ^ {36{flip}};
    #1;
  endtask : step
  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b1, 1'b0, '0, 4'hf, 3'b101, 1'b0);
  endtask : idle
  ////////////////////////////////////////////////////////////////
  task automatic s_wr;
    for (int k = 0; k < 6; k++) begin
      if (k < 4) step(k != 0, k != 0, 1'b1, {15'h1, 2'(k + 1)}, 4'h0, 3'b001, 1'b0);
      else idle(1);
      chk('0, {oe, 36'h0});
    end
  endtask : s_wr
  task automatic s_rd;
    ord_nx = 1'b1;
    for (int k = 0; k < 8; k++) begin
      if (k < 4) step(k != 0, k == 0, 1'b0, {15'h1, 2'b01 ^ 2'(k)}, 4'hf, 3'b001, 1'b0);
      else if (k == 4) step(1'b0, 1'b1, 1'b0, 17'h6, 4'hf, 3'b001, 1'b0);
      else idle(1);
      if (k >= 2 && k < 7) chk({1'b1, pat(k < 6 ? {15'h1, 2'b01 ^ 2'(k - 2)} : 17'h6)}, {oe, dqo});
    end
    chk('0, {oe, 36'h0});
    ord_nx = 1'b0;
  endtask : s_rd
  task automatic s_lane;
    step(1'b0, 1'b0, 1'b1, 17'h9, 4'h0, 3'b001, 1'b0);
    flip = 1'b1;
    step(1'b0, 1'b0, 1'b1, 17'h9, 4'ha, 3'b001, 1'b0);
    flip = 1'b0;
    step(1'b0, 1'b1, 1'b0, 17'h9, 4'hf, 3'b001, 1'b0);
    idle(2);
    chk({1'b1, pat(17'h9) ^ 36'h0_07fc_01ff}, {oe, dqo});
  endtask : s_lane
  task automatic s_gate;
    step(1'b0, 1'b1, 1'b0, 17'h5, 4'hf, 3'b001, 1'b0);
    for (int k = 1; k < 8; k++) begin
      step(1'b0, 1'b1, 1'b0, 17'h6, 4'hf, 8'h36 >> k & 1 ? 3'b001 : 3'b101, 1'(8'h36 >> k));
      if (k > 3 && k < 7) chk({1'b1, pat(17'h5)}, {oe, dqo});
      else chk('0, {oe, 36'h0});
    end
  endtask : s_gate
  task automatic s_desel;
    logic [2:0] bad [3] = '{3'b101, 3'b011, 3'b000};
    for (int c = 0; c < 3; c++) begin
      step(1'b0, 1'b1, 1'b0, 17'h5, 4'hf, bad[c], 1'b0);
      repeat (3) begin
        idle(1);
        chk('0, {oe, 36'h0});
      end
    end
  endtask : s_desel
  ////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    chk('0, {oe, 36'h0});
    s_wr();
    s_rd();
    s_lane();
    s_gate();
    s_desel();
    conclude();
  end
  initial begin
    repeat (1000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : tb
